// >>> hdl/unit_pkg.sv
package unit_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // boot window over which the address lines are measured
  localparam int unsigned BOOT_MEAS_US = 10_000;
  localparam int unsigned BOOT_MEAS_CYC = BOOT_MEAS_US * CYC_PER_US;
  // fast discharge stays on at least this long after an emergency stop is released
  localparam int unsigned DISCH_HOLD_MS = 1_000;
  localparam int unsigned DISCH_HOLD_CYC = DISCH_HOLD_MS * 1_000 * CYC_PER_US;

  // ****************************************************************
  // identifiers
  // ****************************************************************
  localparam logic [6:0] ID_DEFAULT = 7'h56;
  localparam logic [6:0] ID_FULL_BASE = 7'h4f;
  localparam logic [6:0] ID_HALF_BASE = 7'h56;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DUTY = 4'hc;
  // ctrl bits, write one to act
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_CLR_FAULT_BIT = 2;
  // cfg bits
  localparam int CFG_PERM_EN_BIT = 0;
  localparam logic CFG_PERM_EN_RST = 1'b0;
  // status field positions
  localparam int ST_ID_LSB = 0;
  localparam int ST_ID_VALID_BIT = 7;
  localparam int ST_CFG_FAULT_BIT = 8;
  localparam int ST_START_FAULT_BIT = 9;
  localparam int ST_ESTOP_BIT = 10;
  localparam int ST_CHAIN_BIT = 11;
  localparam int ST_PERM_OK_BIT = 12;
  localparam int ST_POWER_BIT = 13;
  localparam int ST_STATE_LSB = 14;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    DUTY_0 = 2'h0,
    DUTY_50 = 2'h1,
    DUTY_100 = 2'h2
  } duty_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_IDLE = 2'h1,
    ST_RUN = 2'h3,
    ST_LOCK = 2'h2
  } unit_state_t;

endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output moves once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // per bit: accept the value only when the two late stages match
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

endmodule

// >>> hdl/duty_meter.sv
`timescale 1ns/100ps
// measures the high share of each line over one window after reset
module duty_meter #(
  parameter int LINES = 3,
  parameter int unsigned WINDOW = 200_000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LINES-1:0] line,
  output logic done,
  output unit_pkg::duty_t duty [LINES]
);

  localparam int CW = $clog2(WINDOW + 1);
  localparam logic [CW+1:0] LOW_LIM = (CW + 2)'(WINDOW);
  localparam logic [CW+1:0] HIGH_LIM = (CW + 2)'(3 * WINDOW);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // window counter, stops when the window is full
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (!done_ff) begin
      nxt_cnt = cnt_ff + CW'(1);
      nxt_done = (cnt_ff == CW'(WINDOW - 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  // one high counter and classifier per line
  for (genvar g = 0; g < LINES; g++) begin : g_line
    logic [CW-1:0] hi_ff;
    logic [CW-1:0] nxt_hi;
    logic [CW+1:0] hi_x4;

    always_comb begin
      nxt_hi = hi_ff;
      if (!done_ff && line[g]) begin
        nxt_hi = hi_ff + CW'(1);
      end
      hi_x4 = {hi_ff, 2'b00};
      if (hi_x4 < LOW_LIM) begin
        duty[g] = unit_pkg::DUTY_0;
      end else if (hi_x4 > HIGH_LIM) begin
        duty[g] = unit_pkg::DUTY_100;
      end else begin
        duty[g] = unit_pkg::DUTY_50;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hi_ff <= '0;
      end else begin
        hi_ff <= nxt_hi;
      end
    end
  end

  assign done = done_ff;

endmodule

// >>> hdl/unit_ctrl.sv
`timescale 1ns/100ps
// Operation
// - address lines are measured at boot and fix the node identifier then
// - an unconnected address line reads as logic zero
// - an address line tied to isolated ground reads as logic one
// - static code 000 gives 86, 001 to 110 give 80 to 85, 111 illegal
// - pwm lines 0/100% give 80 to 86, 0/50% give 87 to 93
// - emergency stop halts power unconditionally, over any command
// - floating emergency input means stop; 12V or 24V means run
// - emergency stop turns on the fast output discharge
// - with permission enabled, permission loss or stop command halts output
// - permission function is off after reset until enabled
// - permission enabled and low keeps output off; start then faults
// - permission enabled and high lets a start command turn output on
// - a fault on any chained unit disables charging on all of them
module unit_ctrl #(
  parameter int unsigned MEAS_CYCLES = unit_pkg::BOOT_MEAS_CYC,
  parameter int unsigned DISCH_CYCLES = unit_pkg::DISCH_HOLD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2,
  input wire logic addr_pwm_mode,
  input wire logic emergency_stop_in,
  input wire logic charge_perm_in,
  input wire logic chain_fault_line_in,
  output logic chain_fault_line_out,
  output logic chain_fault_line_oe,
  output logic power_enable,
  output logic discharge_enable,
  output logic [6:0] bus_node_identifier,
  output logic id_valid
);

  localparam int DW = $clog2(DISCH_CYCLES + 1);

  // ****************************************************************
  // pin conditioning
  // ****************************************************************
  logic [2:0] addr_pin_lvl;
  logic [2:0] addr_logic;
  logic [3:0] misc_lvl;
  logic estop;
  logic perm_ok;
  logic chain_low;
  logic mode_pwm;
  logic meas_done;
  unit_pkg::duty_t duty [3];

  // address lines pull up when open, so an open line reads high at the pin
  pin_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_addr_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({addr_sel_bit2, addr_sel_bit1, addr_sel_bit0}),
    .level(addr_pin_lvl)
  );

  pin_sync #(.WIDTH(4), .RST_VAL(4'h7)) u_misc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({addr_pwm_mode, chain_fault_line_in, charge_perm_in, emergency_stop_in}),
    .level(misc_lvl)
  );

  assign addr_logic = ~addr_pin_lvl;
  assign estop = ~misc_lvl[0];
  assign perm_ok = ~misc_lvl[1];
  assign chain_low = ~misc_lvl[2];
  assign mode_pwm = misc_lvl[3];

  duty_meter #(.LINES(3), .WINDOW(MEAS_CYCLES)) u_meter (
    .aclk(aclk),
    .aresetn(aresetn),
    .line(addr_logic),
    .done(meas_done),
    .duty(duty)
  );

  // ****************************************************************
  // identifier decoding
  // ****************************************************************
  // returns {illegal, identifier}
  function automatic logic [7:0] decode_id(input logic pwm, input logic [1:0] d2,
                                           input logic [1:0] d1, input logic [1:0] d0);
    logic [2:0] full;
    logic [2:0] half;
    logic [7:0] res;
    full = {d2 == unit_pkg::DUTY_100, d1 == unit_pkg::DUTY_100, d0 == unit_pkg::DUTY_100};
    half = {d2 == unit_pkg::DUTY_50, d1 == unit_pkg::DUTY_50, d0 == unit_pkg::DUTY_50};
    res = {1'b0, unit_pkg::ID_DEFAULT};
    if (!pwm) begin
      if (half != 3'h0 || full == 3'h7) begin
        res = {1'b1, unit_pkg::ID_DEFAULT};
      end else if (full != 3'h0) begin
        res = {1'b0, unit_pkg::ID_FULL_BASE + {4'h0, full}};
      end
    end else begin
      if (half != 3'h0 && full != 3'h0) begin
        res = {1'b1, unit_pkg::ID_DEFAULT};
      end else if (half != 3'h0) begin
        res = {1'b0, unit_pkg::ID_HALF_BASE + {4'h0, half}};
      end else if (full != 3'h0) begin
        res = {1'b0, unit_pkg::ID_FULL_BASE + {4'h0, full}};
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [3:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic perm_en_ff, nxt_perm_en;
  logic wr_fire;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_clr;
  logic [31:0] status_word;
  logic [31:0] duty_word;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign cmd_start = wr_fire && awaddr_ff == unit_pkg::REG_CTRL && wstrb_ff[0]
                     && wdata_ff[unit_pkg::CTRL_START_BIT];
  assign cmd_stop = wr_fire && awaddr_ff == unit_pkg::REG_CTRL && wstrb_ff[0]
                    && wdata_ff[unit_pkg::CTRL_STOP_BIT];
  assign cmd_clr = wr_fire && awaddr_ff == unit_pkg::REG_CTRL && wstrb_ff[0]
                   && wdata_ff[unit_pkg::CTRL_CLR_FAULT_BIT];

  // address and data taken in either order; response once both are held
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_perm_en = perm_en_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = {s_axi_awaddr[3:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = unit_pkg::RESP_OKAY;
      unique case (awaddr_ff)
        unit_pkg::REG_CTRL, unit_pkg::REG_STATUS, unit_pkg::REG_DUTY: begin
        end
        unit_pkg::REG_CFG: begin
          if (wstrb_ff[0]) begin
            nxt_perm_en = wdata_ff[unit_pkg::CFG_PERM_EN_BIT];
          end
        end
        default: nxt_bresp = unit_pkg::RESP_DECERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = unit_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'b00})
        unit_pkg::REG_CTRL: nxt_rdata = 32'h0000_0000;
        unit_pkg::REG_CFG: nxt_rdata = {31'h0000_0000, perm_en_ff};
        unit_pkg::REG_STATUS: nxt_rdata = status_word;
        unit_pkg::REG_DUTY: nxt_rdata = duty_word;
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = unit_pkg::RESP_DECERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // permission function starts disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= unit_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= unit_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      perm_en_ff <= unit_pkg::CFG_PERM_EN_RST;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      perm_en_ff <= nxt_perm_en;
    end
  end

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // ****************************************************************
  // power control
  // ****************************************************************
  unit_pkg::unit_state_t state_ff, nxt_state;
  logic [6:0] id_ff, nxt_id;
  logic id_valid_ff, nxt_id_valid;
  logic cfg_fault_ff, nxt_cfg_fault;
  logic start_fault_ff, nxt_start_fault;
  logic power_ff, nxt_power;
  logic disch_ff, nxt_disch;
  logic [DW-1:0] disch_cnt_ff, nxt_disch_cnt;
  logic chain_oe_ff, nxt_chain_oe;
  logic [7:0] dec;
  logic halt;

  assign dec = decode_id(mode_pwm, duty[2], duty[1], duty[0]);
  // any stop source, emergency first and over everything
  assign halt = estop || cmd_stop || chain_low || (perm_en_ff && !perm_ok);

  always_comb begin
    nxt_state = state_ff;
    nxt_id = id_ff;
    nxt_id_valid = id_valid_ff;
    nxt_cfg_fault = cfg_fault_ff;
    nxt_start_fault = start_fault_ff;
    nxt_disch = disch_ff;
    nxt_disch_cnt = disch_cnt_ff;
    if (cmd_clr) begin
      nxt_start_fault = 1'b0;
    end
    unique case (state_ff)
      unit_pkg::ST_BOOT: begin
        if (meas_done) begin
          nxt_id = dec[6:0];
          nxt_id_valid = !dec[7];
          nxt_cfg_fault = dec[7];
          nxt_state = dec[7] ? unit_pkg::ST_LOCK : unit_pkg::ST_IDLE;
        end
      end
      unit_pkg::ST_IDLE: begin
        if (cmd_start && !halt) begin
          nxt_state = unit_pkg::ST_RUN;
        end else if (cmd_start && perm_en_ff && !perm_ok) begin
          nxt_start_fault = 1'b1;
        end
      end
      unit_pkg::ST_RUN: begin
        if (halt) begin
          nxt_state = unit_pkg::ST_IDLE;
        end
      end
      unit_pkg::ST_LOCK: begin
      end
    endcase
    nxt_power = (nxt_state == unit_pkg::ST_RUN);
    // discharge on while stopped by emergency, then held for the drain time
    if (estop) begin
      nxt_disch = 1'b1;
      nxt_disch_cnt = DW'(DISCH_CYCLES);
    end else if (disch_cnt_ff != '0) begin
      nxt_disch_cnt = disch_cnt_ff - DW'(1);
    end else begin
      nxt_disch = 1'b0;
    end
    nxt_chain_oe = nxt_cfg_fault || nxt_start_fault;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= unit_pkg::ST_BOOT;
      id_ff <= unit_pkg::ID_DEFAULT;
      id_valid_ff <= 1'b0;
      cfg_fault_ff <= 1'b0;
      start_fault_ff <= 1'b0;
      power_ff <= 1'b0;
      disch_ff <= 1'b0;
      disch_cnt_ff <= '0;
      chain_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      id_ff <= nxt_id;
      id_valid_ff <= nxt_id_valid;
      cfg_fault_ff <= nxt_cfg_fault;
      start_fault_ff <= nxt_start_fault;
      power_ff <= nxt_power;
      disch_ff <= nxt_disch;
      disch_cnt_ff <= nxt_disch_cnt;
      chain_oe_ff <= nxt_chain_oe;
    end
  end

  assign status_word = {16'h0000, state_ff, power_ff, perm_ok, chain_low, estop,
                        start_fault_ff, cfg_fault_ff, id_valid_ff, id_ff};
  assign duty_word = {26'h000_0000, duty[2], duty[1], duty[0]};

  assign power_enable = power_ff;
  assign discharge_enable = disch_ff;
  assign bus_node_identifier = id_ff;
  assign id_valid = id_valid_ff;
  assign chain_fault_line_out = 1'b0; // open drain: only ever pulls low
  assign chain_fault_line_oe = chain_oe_ff;

endmodule

// >>> tb/unit_ctrl_chk.sv
`timescale 1ns/100ps
// ****
// port checker for the unit control block
// ****
module unit_ctrl_chk #(
  parameter int unsigned MEAS_CYCLES = 64,
  parameter int unsigned DISCH_CYCLES = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic emergency_stop_in,
  input wire logic chain_fault_line_in,
  input wire logic chain_fault_line_out,
  input wire logic chain_fault_line_oe,
  input wire logic power_enable,
  input wire logic discharge_enable,
  input wire logic [6:0] bus_node_identifier,
  input wire logic id_valid
);
  logic [31:0] boot_cnt_ff;
  logic [31:0] nxt_boot_cnt;
  logic [31:0] run_cnt_ff;
  logic [31:0] nxt_run_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since reset release and since the stop input went back high
  always_comb begin
    nxt_boot_cnt = boot_cnt_ff + 32'h0000_0001;
    nxt_run_cnt = emergency_stop_in ? run_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge aclk) begin
    boot_cnt_ff <= aresetn ? nxt_boot_cnt : 32'h0000_0000;
    run_cnt_ff <= aresetn ? nxt_run_cnt : 32'h0000_0000;
  end
  // long enough for the synchroniser and the state register
  sequence estop_held;
    !emergency_stop_in [*8];
  endsequence
  sequence chain_low_held;
    !chain_fault_line_in [*8];
  endsequence
  AST_ESTOP_OFF: assert property (estop_held |-> !power_enable)
    else $error("power on during emergency stop");
  AST_ESTOP_DISCH: assert property (estop_held |-> discharge_enable)
    else $error("no discharge during emergency stop");
  AST_DISCH_HOLD: assert property ($fell(discharge_enable) |-> run_cnt_ff >= DISCH_CYCLES)
    else $error("discharge ended too early");
  AST_CHAIN_HALT: assert property (chain_low_held |-> !power_enable)
    else $error("power on while chain line low");
  AST_CHAIN_DRIVE: assert property (chain_fault_line_oe |-> !power_enable && !chain_fault_line_out)
    else $error("chain line driven wrongly");
  AST_ID_HELD: assert property (id_valid |=> id_valid && $stable(bus_node_identifier))
    else $error("identifier changed after boot");
  AST_ID_LATE: assert property ($rose(id_valid) |-> boot_cnt_ff >= MEAS_CYCLES)
    else $error("identifier latched before boot window end");
  AST_ID_RANGE: assert property (id_valid |-> bus_node_identifier inside {[7'h50:7'h5d]})
    else $error("identifier out of range");
  AST_POWER_ID: assert property (power_enable |-> id_valid)
    else $error("power on without legal identifier");
endmodule
bind unit_ctrl unit_ctrl_chk #(.MEAS_CYCLES(MEAS_CYCLES), .DISCH_CYCLES(DISCH_CYCLES)) chk (
  .aclk(aclk), .aresetn(aresetn), .emergency_stop_in(emergency_stop_in),
  .chain_fault_line_in(chain_fault_line_in), .chain_fault_line_out(chain_fault_line_out),
  .chain_fault_line_oe(chain_fault_line_oe), .power_enable(power_enable),
  .discharge_enable(discharge_enable), .bus_node_identifier(bus_node_identifier), .id_valid(id_valid));

// >>> tb/harness_model.sv
`timescale 1ns/100ps
// ****
// harness pins facing the unit
// ****
module harness_model (
  input wire logic aclk,
  input wire logic pwm_sel,
  input wire logic [2:0] full_bits,
  input wire logic [2:0] half_bits,
  input wire logic estop_open,
  input wire logic perm_tied,
  input wire logic other_fault,
  input wire logic chain_oe,
  output logic [2:0] addr_pins,
  output logic addr_pwm_mode,
  output logic emergency_stop_in,
  output logic charge_perm_in,
  output logic chain_line
);
  logic [2:0] phase_ff = 3'h0;
  // free running phase of the half duty generator
  always_ff @(posedge aclk) begin
    phase_ff <= phase_ff + 3'h1;
  end
  // a tied line pulls its pin low; a half line is tied half the time
  assign addr_pins = ~(full_bits | (half_bits & {3{phase_ff[2]}}));
  assign addr_pwm_mode = pwm_sel;
  // an open stop loop floats low, supply present holds it high
  assign emergency_stop_in = !estop_open;
  assign charge_perm_in = !perm_tied;
  // line left floating on its pull-up unless some unit pulls it
  assign chain_line = !(chain_oe || other_fault);
endmodule

// >>> tb/test_unit_ctrl.sv
`timescale 1ns/100ps
module test_unit_ctrl;
  localparam int unsigned MEAS = 64;
  localparam int unsigned DISCH = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic pwm_sel = 1'b0, estop_open = 1'b0, perm_tied = 1'b0, other_fault = 1'b0;
  logic [2:0] full_bits = 3'h0;
  logic [2:0] half_bits = 3'h0;
  logic [2:0] addr_pins;
  logic pwm_mode, estop_pin, perm_pin, chain_line, chain_out, chain_oe, power_enable, discharge_enable, id_valid;
  logic [6:0] node_id;
  int n_fail = 0;
  int comparisons = 0;
  // ****
  // clock, design and harness
  // ****
  always #25 aclk = ~aclk;
  unit_ctrl #(.MEAS_CYCLES(MEAS), .DISCH_CYCLES(DISCH)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .addr_sel_bit0(addr_pins[0]), .addr_sel_bit1(addr_pins[1]),
    .addr_sel_bit2(addr_pins[2]), .addr_pwm_mode(pwm_mode), .emergency_stop_in(estop_pin),
    .charge_perm_in(perm_pin), .chain_fault_line_in(chain_line), .chain_fault_line_out(chain_out),
    .chain_fault_line_oe(chain_oe), .power_enable(power_enable), .discharge_enable(discharge_enable),
    .bus_node_identifier(node_id), .id_valid(id_valid));
  harness_model harness (
    .aclk(aclk), .pwm_sel(pwm_sel), .full_bits(full_bits), .half_bits(half_bits), .estop_open(estop_open),
    .perm_tied(perm_tied), .other_fault(other_fault), .chain_oe(chain_oe), .addr_pins(addr_pins),
    .addr_pwm_mode(pwm_mode), .emergency_stop_in(estop_pin), .charge_perm_in(perm_pin), .chain_line(chain_line));
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bus write: valid held until taken, response awaited with a bound
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    check({29'h0, bvalid, bresp}, 32'h0000_0004);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    d = rdata;
    check({29'h0, rvalid, rresp}, 32'h0000_0004);
  endtask
  // command pulse, then let the power register settle
  task automatic pulse(input logic [31:0] d);
    wr(unit_pkg::REG_CTRL, d);
    repeat (2) @(posedge aclk);
  endtask
  // fresh boot with the given selector pattern
  task automatic boot(input logic pwm, input logic [2:0] full, input logic [2:0] half);
    int n;
    n = 0;
    pwm_sel <= pwm;
    full_bits <= full;
    half_bits <= half;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    while (id_valid !== 1'b1 && n < MEAS + 20) begin
      @(posedge aclk);
      n++;
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_static();
    logic [31:0] st;
    for (int c = 0; c < 8; c++) begin
      boot(1'b0, 3'(c), 3'h0);
      if (c == 7) begin
        check({31'h0, id_valid}, 32'h0000_0000);
        rd(unit_pkg::REG_STATUS, st);
        check({31'h0, st[unit_pkg::ST_CFG_FAULT_BIT]}, 32'h0000_0001);
        pulse(32'h0000_0001);
        check({30'h0, power_enable, chain_oe}, 32'h0000_0001);
      end else begin
        check({24'h0, id_valid, node_id}, c == 0 ? 32'h0000_00d6 : 32'h0000_00cf + 32'(c));
      end
    end
    $display("static address test done");
  endtask
  task automatic test_pwm();
    logic [31:0] st;
    boot(1'b1, 3'h1, 3'h2);
    check({31'h0, id_valid}, 32'h0000_0000);
    for (int n = 1; n < 8; n++) begin
      boot(1'b1, 3'(n), 3'h0);
      check({24'h0, id_valid, node_id}, 32'h0000_00cf + 32'(n));
      boot(1'b1, 3'h0, 3'(n));
      check({24'h0, id_valid, node_id}, 32'h0000_00d6 + 32'(n));
    end
    rd(unit_pkg::REG_DUTY, st);
    check(st, 32'h0000_0015);
    $display("pwm address test done");
  endtask
  task automatic test_estop();
    boot(1'b0, 3'h1, 3'h0);
    pulse(32'h0000_0001);
    check({30'h0, power_enable, discharge_enable}, 32'h0000_0002);
    estop_open <= 1'b1;
    repeat (8) @(posedge aclk);
    check({30'h0, power_enable, discharge_enable}, 32'h0000_0001);
    pulse(32'h0000_0001);
    check({31'h0, power_enable}, 32'h0000_0000);
    estop_open <= 1'b0;
    repeat (8) @(posedge aclk);
    check({31'h0, discharge_enable}, 32'h0000_0001);
    repeat (DISCH + 8) @(posedge aclk);
    check({31'h0, discharge_enable}, 32'h0000_0000);
    pulse(32'h0000_0001);
    check({31'h0, power_enable}, 32'h0000_0001);
    pulse(32'h0000_0002);
    check({31'h0, power_enable}, 32'h0000_0000);
    $display("emergency stop test done");
  endtask
  task automatic test_perm();
    logic [31:0] st;
    boot(1'b0, 3'h2, 3'h0);
    rd(unit_pkg::REG_CFG, st);
    check(st, 32'h0000_0000);
    wr(unit_pkg::REG_CFG, 32'h0000_0001);
    pulse(32'h0000_0001);
    rd(unit_pkg::REG_STATUS, st);
    check({29'h0, power_enable, chain_oe, st[unit_pkg::ST_START_FAULT_BIT]}, 32'h0000_0003);
    pulse(32'h0000_0004);
    check({31'h0, chain_oe}, 32'h0000_0000);
    perm_tied <= 1'b1;
    repeat (8) @(posedge aclk);
    pulse(32'h0000_0001);
    check({31'h0, power_enable}, 32'h0000_0001);
    perm_tied <= 1'b0;
    repeat (8) @(posedge aclk);
    check({31'h0, power_enable}, 32'h0000_0000);
    $display("charge permission test done");
  endtask
  task automatic test_chain();
    boot(1'b0, 3'h6, 3'h0);
    pulse(32'h0000_0001);
    other_fault <= 1'b1;
    repeat (8) @(posedge aclk);
    check({30'h0, power_enable, chain_line}, 32'h0000_0000);
    pulse(32'h0000_0001);
    check({31'h0, power_enable}, 32'h0000_0000);
    other_fault <= 1'b0;
    repeat (8) @(posedge aclk);
    pulse(32'h0000_0001);
    check({31'h0, power_enable}, 32'h0000_0001);
    $display("chain fault test done");
  endtask
  // ****
  // verdict
  // ****
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // about 2000 cycles expected; cut off at 20000
  initial begin
    #1_000_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge aclk);
    test_static();
    test_pwm();
    test_estop();
    test_perm();
    test_chain();
    tally_and_finish();
  end
endmodule
